// File: core/ccmseq_ctrl.sv
// CCM sequencing controller: drives the AES coprocessor through a CCM pass
`timescale 1ns/100ps
// What this block does
// (RULE_01) Load all-zero IV before authentication
// (RULE_02) First auth block: flag, nonce, length
// (RULE_03) Auth flag: reserved, AAD bit, tag code
// (RULE_04) Length field six octets, low bits five
// (RULE_05) Nonempty AAD gets two-octet length prefix
// (RULE_06) AAD follows prefix, last block zero-padded
// (RULE_07) Message zero-padded; B0, AAD, message order
// (RULE_08) Keep upper tag bytes, zero the rest
// (RULE_09) Counter block: flag, nonce, nonzero counter
// (RULE_10) Encryption flag holds only five
// (RULE_11) IV load carries CFB/OFB mode together
// (RULE_12) CTR follows tag pass without reload
// (RULE_13) Counter wraps at 32 bits per message
// (RULE_14) Encrypted tag placed after encrypted message
// (RULE_15) Receipt: rightmost tag octets are encrypted tag
// (RULE_16) Pad ciphertext and encrypted tag to blocks
// (RULE_17) Decrypt: tag pass, then CTR, no reload
// (RULE_18) Accept only when reference tag matches
// (RULE_19) Start bit executes two-bit command
// (RULE_20) CBC-MAC mode, last block in CBC
module ccmseq_ctrl
  import ccmseq_pkg::*;
#(
  parameter int BUF_BYTES = 64,
  parameter int MSG_BASE  = 32
)
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Coprocessor pins
  output logic [1:0]       enc_sel,
  output logic             enc_wr,
  output logic             enc_rd,
  output logic [7:0]       enc_wdata,
  input  wire logic [7:0]  enc_rdata
);
  import ccmseq_pkg::*;

  localparam int AW = $clog2(BUF_BYTES);

  ccmseq_state_e st_r, st_nxt;
  ccmseq_phase_e ph_r, ph_nxt;
  logic [15:0]   blk_r, blk_nxt;
  logic [3:0]    k_r, k_nxt;
  logic          pend_r, pend_nxt;
  logic          rq_v_r, rq_v_nxt;
  logic          rq_rd_r, rq_rd_nxt;
  logic [1:0]    rq_sel_r, rq_sel_nxt;
  logic [7:0]    rq_data_r, rq_data_nxt;
  logic [127:0]  tag_r, tag_nxt;
  logic [127:0]  ref_r, ref_nxt;
  logic          done_r, done_nxt, ok_r, ok_nxt, err_r, err_nxt;
  logic          dec_r, dec_nxt;
  logic [4:0]    tlen_r, tlen_nxt;
  logic [15:0]   aad_len_r, aad_len_nxt, msg_len_r, msg_len_nxt;
  logic [71:0]   nonce_r, nonce_nxt;
  logic          pready_r, pready_nxt, perr_r, perr_nxt;
  logic [31:0]   prdata_r, prdata_nxt;
  logic [7:0]    buf_r [BUF_BYTES];
  logic          drv_done;
  logic [7:0]    drv_rdata;
  logic          mem_we;
  logic [AW-1:0] mem_addr;
  logic [7:0]    mem_wdata;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [15:0] ceil_blk(input logic [17:0] n);
    logic [17:0] s;
    s = n + 18'h0000f;
    ceil_blk = s[17:4] > 14'h0 ? {2'h0, s[17:4]} : 16'h0;
  endfunction : ceil_blk

  // Flag at byte 0, nonce in bytes 1..9, 48-bit tail in bytes 10..15
  function automatic logic [7:0] hdr_byte(input logic [3:0] k, input logic [7:0] flag,
                                          input logic [47:0] tail, input logic [71:0] nonce);
    if (k == 4'h0)
      hdr_byte = flag;
    else if (k < HDR_TAIL_BYTE)
      hdr_byte = nonce[8*(9-k) +: 8];
    else
      hdr_byte = tail[8*(15-k) +: 8];
  endfunction : hdr_byte

  function automatic logic [127:0] tag_mask(input logic [4:0] tlen);
    logic [127:0] m;
    m = '0;
    for (int i = 0; i < 16; i++)
      if (i < tlen)
        m[8*(15-i) +: 8] = 8'hff;
    tag_mask = m;
  endfunction : tag_mask

  ////////////////////////////////////////////////////////////////////////////
  // Block counts and the byte fed to the coprocessor
  logic [15:0] aad_blks, msg_blks, nblk;
  logic [19:0] pos;
  logic [7:0]  src_byte, b0_flag;
  logic        grp16, grp_end, last_blk, rdback, in_tag;
  logic [2:0]  blk_mode;
  logic [1:0]  blk_cmd;

  always_comb
  begin
    aad_blks = (aad_len_r == 16'h0) ? 16'h0 : ceil_blk({2'h0, aad_len_r} + 18'(AAD_PREFIX)); // RULE_05
    msg_blks = ceil_blk({2'h0, msg_len_r});
    nblk     = 16'h1;
    if (ph_r == PH_MAC)
      nblk = 16'h1 + aad_blks + msg_blks; // RULE_07
    else if (ph_r == PH_CTR)
      nblk = msg_blks;
    last_blk = (blk_r + 16'h1 == nblk);
    grp16    = !(ph_r == PH_TAG || ph_r == PH_CTR);
    grp_end  = grp16 ? (k_r == 4'hf) : (k_r[1:0] == 2'h3);
    rdback   = (ph_r == PH_MAC || ph_r == PH_TAG || ph_r == PH_CTR);
    in_tag   = ({1'b0, k_r} < tlen_r);
    b0_flag  = {1'b0, aad_len_r != 16'h0, 3'((tlen_r - 5'h2) >> 1), FLAG_L_M1}; // RULE_03 RULE_04
    pos      = {blk_r, k_r};
    src_byte = 8'h00; // RULE_01
    blk_mode = MODE_CBC;
    blk_cmd  = CMD_ENC;
    case (ph_r)
      PH_IV0:
      begin
        blk_mode = MODE_CBCMAC;
        blk_cmd  = CMD_IV;
      end
      PH_MAC:
      begin
        blk_mode = last_blk ? MODE_CBC : MODE_CBCMAC; // RULE_20
        if (blk_r == 16'h0)
          src_byte = hdr_byte(k_r, b0_flag, {32'h0, msg_len_r}, nonce_r); // RULE_02
        else if (blk_r <= aad_blks)
        begin
          pos = {blk_r - 16'h1, k_r};
          if (pos == 20'h0)
            src_byte = aad_len_r[15:8];
          else if (pos == 20'h1)
            src_byte = aad_len_r[7:0];
          else if (pos - 20'h2 < {4'h0, aad_len_r})
            src_byte = buf_r[AW'(pos - 20'h2)]; // RULE_06
        end
        else
        begin
          pos = {blk_r - 16'h1 - aad_blks, k_r};
          if (pos < {4'h0, msg_len_r})
            src_byte = buf_r[AW'(MSG_BASE) + AW'(pos)]; // RULE_07
        end
      end
      PH_A0:
      begin
        blk_mode = TAG_MODE; // RULE_11
        blk_cmd  = CMD_IV;
        src_byte = hdr_byte(k_r, A0_FLAG, INIT_CTR, nonce_r); // RULE_09 RULE_10
      end
      PH_TAG:
      begin
        blk_mode = TAG_MODE;
        if (!dec_r)
          src_byte = tag_r[8*(15-k_r) +: 8];
        else if (in_tag)
          src_byte = buf_r[AW'(MSG_BASE) + AW'(msg_len_r) + AW'(k_r)]; // RULE_15 RULE_16
      end
      PH_CTR:
      begin
        blk_mode = MODE_CTR; // RULE_12 RULE_17
        blk_cmd  = dec_r ? CMD_DEC : CMD_ENC;
        if (pos < {4'h0, msg_len_r})
          src_byte = buf_r[AW'(MSG_BASE) + AW'(pos)]; // RULE_16
      end
      default:
      begin
        src_byte = 8'h00;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB access: one wait state, refusal latched with the answer
  logic acc, wr_ok, in_buf, mapped, start_go, cfg_bad;
  logic [11:0] boff;

  always_comb
  begin
    acc      = psel && penable && pready_r;
    wr_ok    = acc && pwrite && !perr_r;
    boff     = paddr - OFS_BUF_BASE;
    in_buf   = (paddr >= OFS_BUF_BASE) && (boff < 12'(BUF_BYTES)) && (paddr[1:0] == 2'h0);
    mapped   = in_buf || paddr == OFS_CTRL || paddr == OFS_STATUS || paddr == OFS_AAD_LEN ||
               paddr == OFS_MSG_LEN || paddr == OFS_NONCE0 || paddr == OFS_NONCE1 || paddr == OFS_NONCE2;
    pready_nxt = psel && penable && !pready_r;
    perr_nxt   = pready_nxt && (!mapped || (pwrite && st_r != S_IDLE && paddr != OFS_STATUS));
    prdata_nxt = 32'h0;
    if (pready_nxt && !pwrite)
    begin
      case (paddr)
        OFS_CTRL:    prdata_nxt = {23'h0, tlen_r, 2'h0, dec_r, 1'b0};
        OFS_STATUS:  prdata_nxt = {28'h0, err_r, ok_r, done_r, st_r != S_IDLE};
        OFS_AAD_LEN: prdata_nxt = {16'h0, aad_len_r};
        OFS_MSG_LEN: prdata_nxt = {16'h0, msg_len_r};
        OFS_NONCE0:  prdata_nxt = nonce_r[71:40];
        OFS_NONCE1:  prdata_nxt = nonce_r[39:8];
        OFS_NONCE2:  prdata_nxt = {24'h0, nonce_r[7:0]};
        default:
        begin
          if (in_buf)
            for (int i = 0; i < 4; i++)
              prdata_nxt[8*i +: 8] = buf_r[AW'(boff) + AW'(i)];
        end
      endcase
    end
    start_go = wr_ok && paddr == OFS_CTRL && pwdata[CTRL_START_BIT];
    // Bounds also keep the counter far from its 32-bit wrap
    cfg_bad  = pwdata[CTRL_TLEN_LSB +: TLEN_W] < TLEN_MIN || pwdata[CTRL_TLEN_LSB +: TLEN_W] > TLEN_MAX ||
               pwdata[CTRL_TLEN_LSB] || aad_len_r >= AAD_LEN_LIMIT || aad_len_r > 16'(MSG_BASE) ||
               {1'b0, msg_len_r} + 17'(pwdata[CTRL_TLEN_LSB +: TLEN_W]) > 17'(BUF_BYTES - MSG_BASE); // RULE_13
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb
  begin
    st_nxt = st_r; ph_nxt = ph_r; blk_nxt = blk_r; k_nxt = k_r;
    pend_nxt = pend_r; rq_v_nxt = 1'b0; rq_rd_nxt = rq_rd_r; rq_sel_nxt = rq_sel_r;
    rq_data_nxt = rq_data_r; tag_nxt = tag_r; ref_nxt = ref_r;
    done_nxt = done_r; ok_nxt = ok_r; err_nxt = err_r;
    dec_nxt = dec_r; tlen_nxt = tlen_r; aad_len_nxt = aad_len_r; msg_len_nxt = msg_len_r;
    nonce_nxt = nonce_r;
    mem_we = 1'b0; mem_addr = '0; mem_wdata = drv_rdata;
    if (wr_ok && st_r == S_IDLE)
      case (paddr)
        OFS_AAD_LEN: aad_len_nxt = pwdata[15:0];
        OFS_MSG_LEN: msg_len_nxt = pwdata[15:0];
        OFS_NONCE0:  nonce_nxt[71:40] = pwdata;
        OFS_NONCE1:  nonce_nxt[39:8] = pwdata;
        OFS_NONCE2:  nonce_nxt[7:0] = pwdata[7:0];
        default:     nonce_nxt = nonce_r;
      endcase
    if (!pend_r && st_r inside {S_CS, S_WR, S_POLL, S_RD})
    begin
      pend_nxt    = 1'b1;
      rq_v_nxt    = 1'b1;
      rq_rd_nxt   = (st_r == S_POLL || st_r == S_RD);
      rq_sel_nxt  = (st_r == S_CS || st_r == S_POLL) ? SEL_CS : (st_r == S_WR ? SEL_DI : SEL_DO);
      rq_data_nxt = (st_r == S_CS) ? cs_byte(blk_mode, blk_cmd) : src_byte; // RULE_19
    end
    case (st_r)
      S_IDLE:
      begin
        if (start_go)
        begin
          dec_nxt  = pwdata[CTRL_DEC_BIT];
          tlen_nxt = pwdata[CTRL_TLEN_LSB +: TLEN_W];
          done_nxt = 1'b0;
          ok_nxt   = 1'b0;
          err_nxt  = cfg_bad;
          done_nxt = cfg_bad;
          if (!cfg_bad)
          begin
            st_nxt  = S_CS;
            ph_nxt  = pwdata[CTRL_DEC_BIT] ? PH_A0 : PH_IV0; // RULE_17
            blk_nxt = 16'h0;
            tag_nxt = '0;
            ref_nxt = '0;
          end
        end
      end
      S_CS:
        if (drv_done)
        begin
          pend_nxt = 1'b0;
          k_nxt    = 4'h0;
          st_nxt   = S_WR;
        end
      S_WR:
        if (drv_done)
        begin
          pend_nxt = 1'b0;
          if (grp_end)
            st_nxt = S_POLL;
          else
            k_nxt = k_r + 4'h1;
        end
      S_POLL:
        if (drv_done)
        begin
          pend_nxt = 1'b0;
          if (drv_rdata[CS_RDY_BIT])
          begin
            k_nxt  = grp16 ? 4'h0 : {k_r[3:2], 2'h0};
            st_nxt = rdback ? S_RD : S_FIN;
          end
        end
      S_RD:
        if (drv_done)
        begin
          pend_nxt = 1'b0;
          if (ph_r == PH_MAC && last_blk && in_tag) // RULE_08
          begin
            if (dec_r)
              ref_nxt[8*(15-k_r) +: 8] = drv_rdata;
            else
              tag_nxt[8*(15-k_r) +: 8] = drv_rdata;
          end
          else if (ph_r == PH_TAG && in_tag)
          begin
            if (dec_r)
              tag_nxt[8*(15-k_r) +: 8] = drv_rdata; // RULE_08
            else
            begin
              mem_we   = 1'b1;
              mem_addr = AW'(MSG_BASE) + AW'(msg_len_r) + AW'(k_r); // RULE_14
            end
          end
          else if (ph_r == PH_CTR && pos < {4'h0, msg_len_r})
          begin
            mem_we   = 1'b1;
            mem_addr = AW'(MSG_BASE) + AW'(pos);
          end
          if (!grp_end)
            k_nxt = k_r + 4'h1;
          else if (k_r != 4'hf)
          begin
            k_nxt  = k_r + 4'h1;
            st_nxt = S_WR;
          end
          else
            st_nxt = S_FIN;
        end
      S_FIN:
      begin
        // Block finished: next block, next phase or end of pass
        k_nxt = 4'h0;
        if (!last_blk)
        begin
          blk_nxt = blk_r + 16'h1;
          st_nxt  = S_CS;
        end
        else
        begin
          blk_nxt = 16'h0;
          st_nxt  = S_CS;
          case (ph_r)
            PH_IV0: ph_nxt = PH_MAC;
            PH_A0:  ph_nxt = PH_TAG;
            PH_TAG: ph_nxt = (msg_blks != 16'h0) ? PH_CTR : (dec_r ? PH_IV0 : PH_FIN); // RULE_12
            PH_CTR: ph_nxt = dec_r ? PH_IV0 : PH_FIN;
            PH_MAC: ph_nxt = dec_r ? PH_FIN : PH_A0;
            default: ph_nxt = PH_FIN;
          endcase
          if (ph_nxt == PH_FIN)
          begin
            st_nxt   = S_IDLE;
            done_nxt = 1'b1;
            ok_nxt   = dec_r && (tag_r == ref_r); // RULE_18
          end
        end
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= S_IDLE; ph_r <= PH_IV0; blk_r <= 16'h0; k_r <= 4'h0; pend_r <= 1'b0;
      rq_v_r <= 1'b0; rq_rd_r <= 1'b0; rq_sel_r <= SEL_CS; rq_data_r <= 8'h00;
      tag_r <= '0; ref_r <= '0; done_r <= 1'b0; ok_r <= 1'b0; err_r <= 1'b0;
      dec_r <= 1'b0; tlen_r <= TLEN_MAX; aad_len_r <= 16'h0; msg_len_r <= 16'h0; nonce_r <= '0;
      pready_r <= 1'b0; perr_r <= 1'b0; prdata_r <= 32'h0;
    end
    else
    begin
      st_r <= st_nxt; ph_r <= ph_nxt; blk_r <= blk_nxt; k_r <= k_nxt; pend_r <= pend_nxt;
      rq_v_r <= rq_v_nxt; rq_rd_r <= rq_rd_nxt; rq_sel_r <= rq_sel_nxt; rq_data_r <= rq_data_nxt;
      tag_r <= tag_nxt; ref_r <= ref_nxt; done_r <= done_nxt; ok_r <= ok_nxt; err_r <= err_nxt;
      dec_r <= dec_nxt; tlen_r <= tlen_nxt; aad_len_r <= aad_len_nxt; msg_len_r <= msg_len_nxt;
      nonce_r <= nonce_nxt;
      pready_r <= pready_nxt; perr_r <= perr_nxt; prdata_r <= prdata_nxt;
    end
  end

  // Byte buffer: software fills it only while idle, so the two writers never meet
  always_ff @(posedge pclk)
  begin
    if (wr_ok && in_buf && st_r == S_IDLE)
      for (int i = 0; i < 4; i++)
        buf_r[AW'(boff) + AW'(i)] <= pwdata[8*i +: 8];
    else if (mem_we)
      buf_r[mem_addr] <= mem_wdata;
  end

  assign pready  = pready_r;
  assign prdata  = prdata_r;
  assign pslverr = perr_r;

  ccmseq_port u_port (
    .pclk      (pclk),
    .presetn   (presetn),
    .rq_v      (rq_v_r),
    .rq_rd     (rq_rd_r),
    .rq_sel    (rq_sel_r),
    .rq_data   (rq_data_r),
    .done      (drv_done),
    .rdata     (drv_rdata),
    .enc_sel   (enc_sel),
    .enc_wr    (enc_wr),
    .enc_rd    (enc_rd),
    .enc_wdata (enc_wdata),
    .enc_rdata (enc_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic di_w, cs_w;
  assign di_w = rq_v_r && !rq_rd_r && rq_sel_r == SEL_DI;
  assign cs_w = rq_v_r && !rq_rd_r && rq_sel_r == SEL_CS;

  property p_iv_zero;
    di_w && ph_r == PH_IV0 |=> enc_wr && enc_wdata == 8'h00;
  endproperty
  a_iv_zero: assert property (p_iv_zero) else $error("IV byte not zero"); // RULE_01
  property p_b0_flag;
    di_w && ph_r == PH_MAC && blk_r == 16'h0 && k_r == 4'h0 |=> enc_wdata[7] == 1'b0 &&
      enc_wdata[6] == (aad_len_r != 16'h0) && enc_wdata[2:0] == FLAG_L_M1 &&
      enc_wdata[5:3] == 3'((tlen_r >> 1) - 5'h1);
  endproperty
  a_b0_flag: assert property (p_b0_flag) else $error("Bad first block flag"); // RULE_03
  property p_a0_flag;
    di_w && ph_r == PH_A0 && k_r == 4'h0 |=> enc_wdata == A0_FLAG;
  endproperty
  a_a0_flag: assert property (p_a0_flag) else $error("Bad counter block flag"); // RULE_10
  property p_a0_ctr;
    di_w && ph_r == PH_A0 && k_r == 4'hf |=> enc_wdata == INIT_CTR[7:0] && enc_wdata != 8'h00;
  endproperty
  a_a0_ctr: assert property (p_a0_ctr) else $error("Bad initial counter"); // RULE_09
  property p_mac_mode;
    cs_w && ph_r == PH_MAC |=> enc_wdata[6:4] == (last_blk ? MODE_CBC : MODE_CBCMAC);
  endproperty
  a_mac_mode: assert property (p_mac_mode) else $error("Wrong MAC block mode"); // RULE_20
  property p_no_reload;
    cs_w && ph_r == PH_CTR |=> enc_wdata[6:4] == MODE_CTR && enc_wdata[2:1] != CMD_IV;
  endproperty
  a_no_reload: assert property (p_no_reload) else $error("Counter reloaded"); // RULE_12
  property p_iv_mode;
    cs_w && ph_r == PH_A0 |=> enc_wdata[6:4] == TAG_MODE && enc_wdata[2:1] == CMD_IV;
  endproperty
  a_iv_mode: assert property (p_iv_mode) else $error("IV load without mode"); // RULE_11
  property p_start;
    cs_w |=> enc_wr && enc_sel == SEL_CS && enc_wdata[0] ##1 !enc_wr;
  endproperty
  a_start: assert property (p_start) else $error("Command without start"); // RULE_19
  property p_pad;
    di_w && ph_r == PH_CTR && pos >= {4'h0, msg_len_r} |=> enc_wdata == 8'h00;
  endproperty
  a_pad: assert property (p_pad) else $error("Pad byte not zero"); // RULE_16
  property p_trunc;
    $rose(done_r) && !err_r |-> ((tag_r | ref_r) & ~tag_mask(tlen_r)) == 128'h0;
  endproperty
  a_trunc: assert property (p_trunc) else $error("Tag not truncated"); // RULE_08

  c_enc_done: cover property ($rose(done_r) && !dec_r && !err_r);
  c_dec_ok:   cover property ($rose(ok_r));
  c_cfg_err:  cover property ($rose(err_r));
  c_poll_wait: cover property (st_r == S_POLL && drv_done && !drv_rdata[CS_RDY_BIT]);

endmodule : ccmseq_ctrl

// File: core/ccmseq_port.sv
// Byte access engine toward the coprocessor control and data registers
`timescale 1ns/100ps
module ccmseq_port
  import ccmseq_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Request from the sequencer
  input  wire logic       rq_v,
  input  wire logic       rq_rd,
  input  wire logic [1:0] rq_sel,
  input  wire logic [7:0] rq_data,
  output logic            done,
  output logic [7:0]      rdata,
  // Coprocessor pins
  output logic [1:0]      enc_sel,
  output logic            enc_wr,
  output logic            enc_rd,
  output logic [7:0]      enc_wdata,
  input  wire logic [7:0] enc_rdata
);
  import ccmseq_pkg::*;

  logic       stb_r, stb_nxt;
  logic       wr_r, wr_nxt;
  logic       rd_r, rd_nxt;
  logic [1:0] sel_r, sel_nxt;
  logic [7:0] wd_r, wd_nxt;
  logic       done_r, done_nxt;
  logic [7:0] rdat_r, rdat_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // One strobe cycle per request; read data is taken while the strobe stands
  always_comb
  begin
    stb_nxt  = 1'b0;
    wr_nxt   = 1'b0;
    rd_nxt   = 1'b0;
    sel_nxt  = sel_r;
    wd_nxt   = wd_r;
    done_nxt = 1'b0;
    rdat_nxt = rdat_r;
    if (rq_v && !stb_r)
    begin
      stb_nxt = 1'b1;
      wr_nxt  = !rq_rd;
      rd_nxt  = rq_rd;
      sel_nxt = rq_sel;
      wd_nxt  = rq_data;
    end
    if (stb_r)
    begin
      done_nxt = 1'b1;
      if (rd_r)
        rdat_nxt = enc_rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stb_r  <= 1'b0;
      wr_r   <= 1'b0;
      rd_r   <= 1'b0;
      sel_r  <= 2'h0;
      wd_r   <= 8'h00;
      done_r <= 1'b0;
      rdat_r <= 8'h00;
    end
    else
    begin
      stb_r  <= stb_nxt;
      wr_r   <= wr_nxt;
      rd_r   <= rd_nxt;
      sel_r  <= sel_nxt;
      wd_r   <= wd_nxt;
      done_r <= done_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign enc_sel   = sel_r;
  assign enc_wr    = wr_r;
  assign enc_rd    = rd_r;
  assign enc_wdata = wd_r;
  assign done      = done_r;
  assign rdata     = rdat_r;

endmodule : ccmseq_port

// File: shared/ccmseq_pkg.sv
// Constants, encodings and state types for the CCM sequencing controller
package ccmseq_pkg;

  // APB register offsets of the controller
  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_STATUS   = 12'h004;
  localparam logic [11:0] OFS_AAD_LEN  = 12'h008;
  localparam logic [11:0] OFS_MSG_LEN  = 12'h00c;
  localparam logic [11:0] OFS_NONCE0   = 12'h010;
  localparam logic [11:0] OFS_NONCE1   = 12'h014;
  localparam logic [11:0] OFS_NONCE2   = 12'h018;
  localparam logic [11:0] OFS_BUF_BASE = 12'h100;

  // Field positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_DEC_BIT   = 1;
  localparam int CTRL_TLEN_LSB  = 4;
  localparam int TLEN_W         = 5;
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_DONE_BIT    = 1;
  localparam int ST_OK_BIT      = 2;
  localparam int ST_ERR_BIT     = 3;
  localparam int CS_RDY_BIT     = 3;

  // Coprocessor register selects
  localparam logic [1:0] SEL_CS = 2'h0;
  localparam logic [1:0] SEL_DI = 2'h1;
  localparam logic [1:0] SEL_DO = 2'h2;

  // Coprocessor modes and commands
  localparam logic [2:0] MODE_CBC    = 3'h0;
  localparam logic [2:0] MODE_CFB    = 3'h1;
  localparam logic [2:0] MODE_OFB    = 3'h2;
  localparam logic [2:0] MODE_CTR    = 3'h3;
  localparam logic [2:0] MODE_CBCMAC = 3'h5;
  localparam logic [1:0] CMD_ENC     = 2'h0;
  localparam logic [1:0] CMD_DEC     = 2'h1;
  localparam logic [1:0] CMD_KEY     = 2'h2;
  localparam logic [1:0] CMD_IV      = 2'h3;
  // OFB is symmetric, so the same tag pass serves both directions
  localparam logic [2:0] TAG_MODE    = MODE_OFB;

  // CCM formatting constants
  localparam logic [2:0]  FLAG_L_M1      = 3'h5;
  localparam logic [7:0]  A0_FLAG        = 8'h05;
  localparam logic [47:0] INIT_CTR       = 48'h000000000001;
  localparam logic [15:0] AAD_LEN_LIMIT  = 16'hff00;
  localparam logic [3:0]  HDR_TAIL_BYTE  = 4'ha;
  localparam logic [4:0]  TLEN_MIN       = 5'h04;
  localparam logic [4:0]  TLEN_MAX       = 5'h10;
  localparam logic [4:0]  AAD_PREFIX     = 5'h02;

  typedef enum logic [2:0] {PH_IV0, PH_MAC, PH_A0, PH_TAG, PH_CTR, PH_FIN} ccmseq_phase_e;
  typedef enum logic [2:0] {S_IDLE, S_CS, S_WR, S_POLL, S_RD, S_FIN} ccmseq_state_e;

  // Control byte: start bit always set with mode and command
  function automatic logic [7:0] cs_byte(input logic [2:0] mode, input logic [1:0] cmd);
    cs_byte = {1'b0, mode, 1'b0, cmd, 1'b1};
  endfunction : cs_byte

endpackage : ccmseq_pkg

// File: tb/ccmseq_dev_model.sv
// Behavioural coprocessor with a toy block function
`timescale 1ns/100ps
module ccmseq_dev_model
  import ccmseq_pkg::*;
(
  // Clock
  input  wire logic       pclk,
  // Register pins
  input  wire logic [1:0] enc_sel,
  input  wire logic       enc_wr,
  input  wire logic       enc_rd,
  input  wire logic [7:0] enc_wdata,
  output logic [7:0]      enc_rdata
);
  logic [127:0] iv = 0, ks = 0, blk = 0, res = 0, t;
  logic [3:0]   n = 0, m = 0;
  logic [2:0]   mode = 0;
  logic [1:0]   cmd = 0;
  logic [2:0]   wait_c = 0;
  logic [7:0]   v;
  // Not a real cipher: only has to be the same function in both directions
  function automatic logic [127:0] ef(input logic [127:0] x);
    ef = {x[119:0], x[127:120]} ^ 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
  endfunction : ef
  always @(posedge pclk)
  begin
    if (wait_c != 0)
      wait_c <= wait_c - 1;
    if (enc_rd && enc_sel == SEL_DO)
      m <= m + 1;
    if (enc_wr && enc_sel == SEL_CS)
    begin
      mode <= enc_wdata[6:4];
      cmd <= enc_wdata[2:1];
      n <= 0;
      m <= 0;
      t = ef(iv);
      if (enc_wdata[2:1] != CMD_IV && enc_wdata[6:4] == MODE_OFB)
      begin
        ks <= t;
        iv <= t;
      end
      if (enc_wdata[2:1] != CMD_IV && enc_wdata[6:4] == MODE_CTR)
      begin
        ks <= t;
        iv[31:0] <= iv[31:0] + 1;
      end
    end
    if (enc_wr && enc_sel == SEL_DI)
    begin
      t = blk;
      t[127 - 8 * n -: 8] = enc_wdata;
      blk <= t;
      n <= n + 1;
      // Slow answer after every fourth byte, so the ready poll really waits
      wait_c <= (n[1:0] == 2'h3) ? 3'h7 : 3'h0;
      if (cmd == CMD_IV && n == 15)
        iv <= t;
      else if (cmd != CMD_IV && (mode == MODE_OFB || mode == MODE_CTR))
        res[127 - 8 * n -: 8] <= enc_wdata ^ ks[127 - 8 * n -: 8];
      else if (cmd != CMD_IV && n == 15)
      begin
        res <= ef(iv ^ t);
        iv <= ef(iv ^ t);
      end
    end
  end
  always_comb
  begin
    v = (enc_sel == SEL_CS) ? {1'b0, mode, wait_c == 0, cmd, 1'b0} : res[127 - 8 * m -: 8];
    enc_rdata = enc_rd ? v : ~v;
  end
endmodule : ccmseq_dev_model

// File: tb/test_ccmseq_ctrl.sv
// Self-checking bench: CCM round trips through the toy coprocessor
`timescale 1ns/100ps
module test_ccmseq_ctrl;
  import ccmseq_pkg::*;
  localparam int MB = 32;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, enc_wr, enc_rd, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q, d, st;
  logic [1:0]  enc_sel;
  logic [7:0]  enc_wdata, enc_rdata, pt[32];
  int          err_count = 0, check_count = 0, seed = 15231, m, al, ml, i, w, b, k;
  always #2.5 pclk = ~pclk;
  ccmseq_ctrl #(.BUF_BYTES(64), .MSG_BASE(MB)) u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .enc_sel(enc_sel), .enc_wr(enc_wr), .enc_rd(enc_rd), .enc_wdata(enc_wdata),
    .enc_rdata(enc_rdata));
  ccmseq_dev_model u_dev (.pclk(pclk), .enc_sel(enc_sel), .enc_wr(enc_wr), .enc_rd(enc_rd),
    .enc_wdata(enc_wdata), .enc_rdata(enc_rdata));
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  // A start is taken only for an even tag length inside the legal range
  function automatic logic cfg_ok(input int t);
    cfg_ok = t % 2 == 0 && t >= TLEN_MIN && t <= TLEN_MAX;
  endfunction : cfg_ok
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata, penable} <= {1'b1, wr, a, dat, 1'b0};
    @(posedge pclk);
    penable <= 1;
    for (k = 0; k < 20 && pready !== 1'b1; k++)
      @(posedge pclk);
    if (k == 20)
    begin
      err_count++;
      conclude();
    end
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic run(input logic dec, input int t);
    apb(1, OFS_CTRL, {23'h0, t[4:0], 2'h0, dec, 1'b1});
    apb(1, OFS_AAD_LEN, 0);
    chk("busy_wr", 32'(e), 32'(cfg_ok(t)));
    for (w = 0; w < 1000 && q[ST_DONE_BIT] !== 1'b1; w++)
      apb(0, OFS_STATUS, 0);
    st = q;
    if (w == 1000)
    begin
      err_count++;
      conclude();
    end
  endtask : run
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    apb(0, OFS_STATUS, 0);
    chk("status_rst", q, 0);
    apb(0, 12'h020, 0);
    chk("unmapped", 32'(e), 1);
    run(0, 5);
    chk("odd_m", st[3:0], 4'ha);
    run(0, 18);
    chk("big_m", st[3:0], 4'ha);
    for (i = 0; i < 6; i++)
    begin
      m = (i == 1) ? 16 : 4 + 2 * ($unsigned($random(seed)) % 7);
      al = $unsigned($random(seed)) % 33;
      ml = (i == 0) ? 0 : $unsigned($random(seed)) % (33 - m);
      for (w = 0; w < 3; w++)
        apb(1, 12'(OFS_NONCE0 + 4 * w), $random(seed));
      for (b = 0; b < 16; b++)
      begin
        d = $random(seed);
        apb(1, 12'(OFS_BUF_BASE + 4 * b), d);
        for (w = 0; w < 4 && b >= 8; w++)
          pt[4 * b - 32 + w] = d[8 * w +: 8];
      end
      apb(1, OFS_AAD_LEN, al);
      apb(1, OFS_MSG_LEN, ml);
      run(0, m);
      chk("enc_status", st[3:0], 4'h2);
      // Odd runs corrupt one octet of the encrypted tag
      if (i % 2 == 1)
      begin
        apb(0, 12'(OFS_BUF_BASE + MB + (ml & ~3)), 0);
        apb(1, 12'(OFS_BUF_BASE + MB + (ml & ~3)), q ^ (32'h1 << 8 * (ml % 4)));
      end
      run(1, m);
      chk("dec_status", st[3:0], {1'b0, i % 2 == 0, 2'b10});
      for (b = 0; b < ml; b += 4)
      begin
        apb(0, 12'(OFS_BUF_BASE + MB + b), 0);
        for (w = 0; w < 4 && b + w < ml; w++)
          chk("plain", 32'(q[8 * w +: 8]), 32'(pt[b + w]));
      end
      $display("test %0d done", i);
    end
    conclude();
  end
endmodule : test_ccmseq_ctrl
